/* File: include/ppc_consts.svh */
// register offsets, field positions, reset values and level limits
// assumes: included by the privilege check design file
`ifndef PPC_CONSTS_SVH
`define PPC_CONSTS_SVH
`define PPC_OFS_CTRL      8'h00
`define PPC_OFS_STATUS    8'h04
`define PPC_OFS_SAVED_SS  8'h08
`define PPC_OFS_SAVED_SP  8'h0C
`define PPC_CTRL_PROT     0
`define PPC_CTRL_TASK32   1
`define PPC_CTRL_IOLVL_LO 4
`define PPC_CTRL_IOLVL_HI 5
`define PPC_ST_LVL_LO     0
`define PPC_ST_LVL_HI     1
`define PPC_ST_REAL       2
`define PPC_ST_DENIED     3
`define PPC_ST_CAUSE_LO   8
`define PPC_ST_CAUSE_HI   10
`define PPC_ST_CNT_LO     16
`define PPC_ST_CNT_HI     31
`define PPC_LEVEL_MOST    2'h0
`define PPC_LEVEL_LEAST   2'h3
`define PPC_RST_SS        16'h0000
`define PPC_RST_SP        32'h0000_0000
`define PPC_RST_CNT       16'h0000
`define PPC_CNT_ONE       16'h0001
`define PPC_RD_ZERO       32'h0000_0000
`endif

/* File: include/ppc_pkg.sv */
// types of the segment privilege check block
// assumes: the pipeline encodes its requests with these enums
package ppc_pkg;
  // io port covers port in/out, string forms and repeated forms;
  // io flag covers interrupt-flag clear/set and any change of it
  typedef enum logic [3:0] {
    PPC_OP_DATA       = 4'h0,
    PPC_OP_JUMP       = 4'h1,
    PPC_OP_CALL       = 4'h2,
    PPC_OP_RETURN     = 4'h3,
    PPC_OP_INT_RETURN = 4'h4,
    PPC_OP_INTR       = 4'h5,
    PPC_OP_IO_PORT    = 4'h6,
    PPC_OP_IO_FLAG    = 4'h7
  } ppc_op_t;
  typedef enum logic [2:0] {
    PPC_DESC_CODE       = 3'h0,
    PPC_DESC_DATA       = 3'h1,
    PPC_DESC_CALL_GATE  = 3'h2,
    PPC_DESC_TRAP_GATE  = 3'h3,
    PPC_DESC_INT_GATE   = 3'h4,
    PPC_DESC_TASK_GATE  = 3'h5,
    PPC_DESC_TASK_STATE = 3'h6
  } ppc_desc_t;
  typedef enum logic [1:0] {
    PPC_TBL_GLOBAL = 2'h0,
    PPC_TBL_LOCAL  = 2'h1,
    PPC_TBL_INTR   = 2'h2
  } ppc_tbl_t;
  typedef enum logic [2:0] {
    PPC_CAUSE_NONE  = 3'h0,
    PPC_CAUSE_PRIV  = 3'h1,
    PPC_CAUSE_IO    = 3'h2,
    PPC_CAUSE_TYPE  = 3'h3,
    PPC_CAUSE_LEVEL = 3'h4
  } ppc_cause_t;
endpackage

/* File: design/ppc_priv_check.sv */
// segment privilege check: access, io and control-transfer checks, stack switch
// assumes: requests come from same-clock pipeline logic; software on APB
// Function
// - privilege is two bits, 0 most privileged
// - real mode runs as level 0
// - running level held as code segment level
// - effective level is larger of requested, running
// - access only if effective <= descriptor level
// - data from equal/higher, calls from equal/lower
// - port io and interrupt-flag ops are io-sensitive
// - io level in flags, set only at level 0
// - running <= io level: sensitive ops pass
// - 16-bit task state: sensitive ops fault
// - 32-bit task state: bitmap per port
// - running level changes only via gates/task switch; code also changes it on outward return
// - wrong descriptor type for transfer faults
// - same-level transfers need global/local code descriptor
// - inward call needs global/local call gate
// - interrupts use trap/interrupt gate from interrupt table
// - outward return needs global/local code descriptor
// - interrupt-path task switch needs interrupt-table task gate
// - level change inside task switches stack
// - inner stacks for levels 0-2 from task state
// - inward: load new stack, push old pointer
// - outward return restores saved outer stack
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/10ps
`include "ppc_consts.svh"

module ppc_priv_check
  import ppc_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              reqValid,
  input  ppc_op_t                reqOp,
  input  wire logic [1:0]        reqSelLevel,
  input  wire logic [1:0]        reqDescLevel,
  input  ppc_desc_t              reqDescType,
  input  ppc_tbl_t               reqDescTable,
  input  wire logic [1:0]        reqTargetLevel,
  input  wire logic              reqPortDenied,
  input  wire logic [15:0]       reqCurSs,
  input  wire logic [31:0]       reqCurSp,
  input  wire logic [15:0]       taskStackSs,
  input  wire logic [31:0]       taskStackSp,
  output logic                   rspValid,
  output logic                   rspFault,
  output ppc_cause_t             rspCause,
  output logic                   rspStackLoad,
  output logic                   rspStackPush,
  output logic                   rspStackRestore,
  output logic [15:0]            rspStackSs,
  output logic [31:0]            rspStackSp,
  output logic [1:0]             runningPrivLevel,
  output logic [1:0]             ioPrivLevel
);

  function automatic logic [1:0] maxLevel(input logic [1:0] a, input logic [1:0] b);
    maxLevel = (a > b) ? a : b;
  endfunction

  function automatic logic isOfs(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    isOfs = (a == ADDR_W'(ofs));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [1:0]  runningPrivLevel_r;
  logic [1:0]  ioPrivLevel_r;
  logic        protEn_r;
  logic        task32_r;
  logic        denied_r;
  ppc_cause_t  lastCause_r;
  logic [15:0] faultCnt_r;
  logic [15:0] savedSs_r;
  logic [31:0] savedSp_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] prdata_r;
  logic        rspValid_r;
  logic        rspFault_r;
  ppc_cause_t  rspCause_r;
  logic        rspStackLoad_r;
  logic        rspStackPush_r;
  logic        rspStackRestore_r;
  logic [15:0] rspStackSs_r;
  logic [31:0] rspStackSp_r;

  ////////////////////////////////////////////////////////////////////////////
  // privilege arithmetic
  wire [1:0] curLvl   = protEn_r ? runningPrivLevel_r : `PPC_LEVEL_MOST;
  wire [1:0] effLvl   = maxLevel(reqSelLevel, curLvl);
  wire       privOk   = (effLvl <= reqDescLevel);
  wire       globLoc  = (reqDescTable == PPC_TBL_GLOBAL) || (reqDescTable == PPC_TBL_LOCAL);
  wire       intrTbl  = (reqDescTable == PPC_TBL_INTR);
  wire       isIoOp   = (reqOp == PPC_OP_IO_PORT) || (reqOp == PPC_OP_IO_FLAG);
  wire       ioLvlOk  = (curLvl <= ioPrivLevel_r);
  wire       bitmapOk = task32_r && (reqOp == PPC_OP_IO_PORT) && !reqPortDenied;
  wire       ioOk     = ioLvlOk || bitmapOk;
  wire       codeGL   = (reqDescType == PPC_DESC_CODE) && globLoc;
  wire       tgtIn    = (reqTargetLevel < curLvl);
  wire       tgtOut   = (reqTargetLevel > curLvl);
  wire       taskJump = ((reqDescType == PPC_DESC_TASK_STATE) && (reqDescTable == PPC_TBL_GLOBAL))
                     || ((reqDescType == PPC_DESC_TASK_GATE) && globLoc);
  wire       taskIntr = (reqDescType == PPC_DESC_TASK_GATE) && intrTbl;
  wire       intGate  = ((reqDescType == PPC_DESC_TRAP_GATE) || (reqDescType == PPC_DESC_INT_GATE))
                     && intrTbl;

  ////////////////////////////////////////////////////////////////////////////
  // decision
  ppc_cause_t cause;
  logic [1:0] newLvl;
  logic       goIn;
  logic       goOut;

  always_comb begin
    cause  = PPC_CAUSE_NONE;
    newLvl = curLvl;
    goIn   = 1'b0;
    goOut  = 1'b0;
    case (reqOp)
      PPC_OP_DATA: begin
        if (!privOk) cause = PPC_CAUSE_PRIV;
      end
      PPC_OP_IO_PORT, PPC_OP_IO_FLAG: begin
        if (!ioOk) cause = PPC_CAUSE_IO;
      end
      PPC_OP_JUMP, PPC_OP_CALL: begin
        if (codeGL) begin
          if (reqTargetLevel != curLvl) cause = PPC_CAUSE_LEVEL;
        end else if ((reqDescType == PPC_DESC_CALL_GATE) && globLoc && (reqOp == PPC_OP_CALL)) begin
          if (!privOk) cause = PPC_CAUSE_PRIV;
          else if (tgtOut) cause = PPC_CAUSE_LEVEL;
          else begin
            newLvl = reqTargetLevel;
            goIn   = tgtIn;
          end
        end else if (taskJump) begin
          if (!privOk) cause = PPC_CAUSE_PRIV;
          else newLvl = reqTargetLevel;
        end else begin
          cause = PPC_CAUSE_TYPE;
        end
      end
      PPC_OP_RETURN, PPC_OP_INT_RETURN: begin
        if (codeGL) begin
          if (tgtIn) cause = PPC_CAUSE_LEVEL;
          else begin
            newLvl = reqTargetLevel;
            goOut  = tgtOut;
          end
        end else if (taskIntr && (reqOp == PPC_OP_INT_RETURN)) begin
          newLvl = reqTargetLevel;
        end else begin
          cause = PPC_CAUSE_TYPE;
        end
      end
      PPC_OP_INTR: begin
        if (intGate) begin
          if (!privOk) cause = PPC_CAUSE_PRIV;
          else if (tgtOut) cause = PPC_CAUSE_LEVEL;
          else begin
            newLvl = reqTargetLevel;
            goIn   = tgtIn;
          end
        end else if (taskIntr) begin
          if (!privOk) cause = PPC_CAUSE_PRIV;
          else newLvl = reqTargetLevel;
        end else begin
          cause = PPC_CAUSE_TYPE;
        end
      end
      default: cause = PPC_CAUSE_TYPE;
    endcase
    if (!protEn_r) begin
      cause  = PPC_CAUSE_NONE;
      newLvl = curLvl;
      goIn   = 1'b0;
      goOut  = 1'b0;
    end
  end

  wire fault = (cause != PPC_CAUSE_NONE);
  wire okReq = reqValid && !fault;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire apbAcc   = psel && penable;
  wire apbDone  = apbAcc && pready_r;
  wire hitCtrl  = isOfs(paddr, `PPC_OFS_CTRL);
  wire hitStat  = isOfs(paddr, `PPC_OFS_STATUS);
  wire hitSs    = isOfs(paddr, `PPC_OFS_SAVED_SS);
  wire hitSp    = isOfs(paddr, `PPC_OFS_SAVED_SP);
  wire mapped   = hitCtrl || hitStat || hitSs || hitSp;
  wire ctrlWr   = apbDone && pwrite && hitCtrl && pstrb[0] && !pslverr_r;
  wire lvlZero  = (curLvl == `PPC_LEVEL_MOST);
  wire ioLvlWr  = ctrlWr && lvlZero;
  wire ioLvlBad = ctrlWr && !lvlZero
               && (pwdata[`PPC_CTRL_IOLVL_HI:`PPC_CTRL_IOLVL_LO] != ioPrivLevel_r);
  wire deniedClr = apbDone && pwrite && hitStat && pstrb[0] && pwdata[`PPC_ST_DENIED];

  logic [31:0] ctrlRd;
  logic [31:0] statRd;
  always_comb begin
    ctrlRd = `PPC_RD_ZERO;
    ctrlRd[`PPC_CTRL_PROT] = protEn_r;
    ctrlRd[`PPC_CTRL_TASK32] = task32_r;
    ctrlRd[`PPC_CTRL_IOLVL_HI:`PPC_CTRL_IOLVL_LO] = ioPrivLevel_r;
    statRd = `PPC_RD_ZERO;
    statRd[`PPC_ST_LVL_HI:`PPC_ST_LVL_LO] = curLvl;
    statRd[`PPC_ST_REAL] = !protEn_r;
    statRd[`PPC_ST_DENIED] = denied_r;
    statRd[`PPC_ST_CAUSE_HI:`PPC_ST_CAUSE_LO] = lastCause_r;
    statRd[`PPC_ST_CNT_HI:`PPC_ST_CNT_LO] = faultCnt_r;
  end

  wire [31:0] rdMux = hitCtrl ? ctrlRd
                    : hitStat ? statRd
                    : hitSs   ? {16'h0000, savedSs_r}
                    : hitSp   ? savedSp_r
                    : `PPC_RD_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `PPC_RD_ZERO;
    end else begin
      pready_r  <= apbAcc && !pready_r;
      pslverr_r <= apbAcc && !pready_r && !mapped;
      if (apbAcc && !pready_r) prdata_r <= pwrite ? `PPC_RD_ZERO : rdMux;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      protEn_r      <= 1'b0;
      task32_r      <= 1'b0;
      ioPrivLevel_r <= `PPC_LEVEL_MOST;
      denied_r      <= 1'b0;
    end else begin
      if (ctrlWr) protEn_r <= pwdata[`PPC_CTRL_PROT];
      if (ctrlWr) task32_r <= pwdata[`PPC_CTRL_TASK32];
      if (ioLvlWr) ioPrivLevel_r <= pwdata[`PPC_CTRL_IOLVL_HI:`PPC_CTRL_IOLVL_LO];
      if (ioLvlBad) denied_r <= 1'b1;
      else if (deniedClr) denied_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // check result and running level
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      runningPrivLevel_r <= `PPC_LEVEL_MOST;
      savedSs_r          <= `PPC_RST_SS;
      savedSp_r          <= `PPC_RST_SP;
      lastCause_r        <= PPC_CAUSE_NONE;
      faultCnt_r         <= `PPC_RST_CNT;
    end else if (reqValid) begin
      if (okReq) runningPrivLevel_r <= newLvl;
      if (okReq && goIn) savedSs_r <= reqCurSs;
      if (okReq && goIn) savedSp_r <= reqCurSp;
      if (fault) lastCause_r <= cause;
      if (fault) faultCnt_r <= 16'(faultCnt_r + `PPC_CNT_ONE);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rspValid_r        <= 1'b0;
      rspFault_r        <= 1'b0;
      rspCause_r        <= PPC_CAUSE_NONE;
      rspStackLoad_r    <= 1'b0;
      rspStackPush_r    <= 1'b0;
      rspStackRestore_r <= 1'b0;
      rspStackSs_r      <= `PPC_RST_SS;
      rspStackSp_r      <= `PPC_RST_SP;
    end else begin
      rspValid_r        <= reqValid;
      rspFault_r        <= reqValid && fault;
      rspCause_r        <= reqValid ? cause : PPC_CAUSE_NONE;
      rspStackLoad_r    <= okReq && (goIn || goOut);
      rspStackPush_r    <= okReq && goIn;
      rspStackRestore_r <= okReq && goOut;
      rspStackSs_r      <= goIn ? taskStackSs : savedSs_r;
      rspStackSp_r      <= goIn ? taskStackSp : savedSp_r;
    end
  end

  assign prdata           = prdata_r;
  assign pready           = pready_r;
  assign pslverr          = pslverr_r;
  assign rspValid         = rspValid_r;
  assign rspFault         = rspFault_r;
  assign rspCause         = rspCause_r;
  assign rspStackLoad     = rspStackLoad_r;
  assign rspStackPush     = rspStackPush_r;
  assign rspStackRestore  = rspStackRestore_r;
  assign rspStackSs       = rspStackSs_r;
  assign rspStackSp       = rspStackSp_r;
  assign runningPrivLevel = runningPrivLevel_r;
  assign ioPrivLevel      = ioPrivLevel_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_fault_keeps_level;
    @(posedge sys_clk) disable iff (!rstn)
    rspFault_r |-> (runningPrivLevel_r == $past(runningPrivLevel_r)) && !rspStackLoad_r;
  endproperty
  a_fault_keeps_level: assert property (p_fault_keeps_level) else $error("fault changed state");

  property p_data_priv;
    @(posedge sys_clk) disable iff (!rstn)
    (reqValid && protEn_r && reqOp == PPC_OP_DATA && maxLevel(reqSelLevel, runningPrivLevel_r) > reqDescLevel)
      |=> rspValid_r && rspFault_r && rspCause_r == PPC_CAUSE_PRIV;
  endproperty
  a_data_priv: assert property (p_data_priv) else $error("data access not refused");

  property p_real_no_fault;
    @(posedge sys_clk) disable iff (!rstn)
    (reqValid && !protEn_r) |=> rspValid_r && !rspFault_r;
  endproperty
  a_real_no_fault: assert property (p_real_no_fault) else $error("fault in real mode");

  property p_io_ok;
    @(posedge sys_clk) disable iff (!rstn)
    (reqValid && isIoOp && protEn_r && runningPrivLevel_r <= ioPrivLevel_r) |=> !rspFault_r;
  endproperty
  a_io_ok: assert property (p_io_ok) else $error("io op faulted within io level");

  property p_io_task16;
    @(posedge sys_clk) disable iff (!rstn)
    (reqValid && isIoOp && protEn_r && !task32_r && runningPrivLevel_r > ioPrivLevel_r)
      |=> rspFault_r && rspCause_r == PPC_CAUSE_IO;
  endproperty
  a_io_task16: assert property (p_io_task16) else $error("io op passed with 16-bit task");

  property p_inward_stack;
    @(posedge sys_clk) disable iff (!rstn)
    rspStackPush_r |-> rspStackLoad_r && (runningPrivLevel_r < $past(runningPrivLevel_r))
      && savedSp_r == $past(reqCurSp);
  endproperty
  a_inward_stack: assert property (p_inward_stack) else $error("inward stack switch wrong");

  property p_outward_restore;
    @(posedge sys_clk) disable iff (!rstn)
    rspStackRestore_r |-> (rspStackSp_r == savedSp_r) && (rspStackSs_r == savedSs_r)
      && (runningPrivLevel_r > $past(runningPrivLevel_r));
  endproperty
  a_outward_restore: assert property (p_outward_restore) else $error("outer stack not restored");

  property p_level_change_cause;
    @(posedge sys_clk) disable iff (!rstn)
    (runningPrivLevel_r != $past(runningPrivLevel_r))
      |-> rspValid_r && !rspFault_r && $past(reqOp) != PPC_OP_DATA && !$past(isIoOp);
  endproperty
  a_level_change_cause: assert property (p_level_change_cause) else $error("level changed oddly");

  property p_io_level_guard;
    @(posedge sys_clk) disable iff (!rstn)
    (ioPrivLevel_r != $past(ioPrivLevel_r)) |-> $past(lvlZero) && $past(ctrlWr);
  endproperty
  a_io_level_guard: assert property (p_io_level_guard) else $error("io level set off level 0");

  property p_bad_type;
    @(posedge sys_clk) disable iff (!rstn)
    (reqValid && protEn_r && reqOp == PPC_OP_INTR && !intGate && !taskIntr)
      |=> rspFault_r && rspCause_r == PPC_CAUSE_TYPE;
  endproperty
  a_bad_type: assert property (p_bad_type) else $error("wrong interrupt descriptor passed");

endmodule // ppc_priv_check

/* File: sim/ppc_task_mem.sv */
// model of the task-state stack table and io permission bitmap
// assumes: looked up combinationally from the pipeline request fields
`timescale 1ns/10ps
module ppc_task_mem #(
  parameter logic [7:0] PORT_DENY = 8'h20
) (
  input  wire logic [1:0]  targetLevel,
  input  wire logic [2:0]  portNum,
  output logic      [15:0] stackSs,
  output logic      [31:0] stackSp,
  output logic             portDenied
);
  ////////////////////////////////////////////////////////////////
  // inner stacks for levels 0-2; level 3 has none
  assign stackSs    = (targetLevel == 2'h3) ? 16'hFFFF : {14'h1400, targetLevel};
  assign stackSp    = (targetLevel == 2'h3) ? 32'hFFFF_FFFF : {30'h1C00_0000, targetLevel};
  // one deny bit per port
  assign portDenied = PORT_DENY[portNum];
endmodule // ppc_task_mem

/* File: sim/tb_privilege_protection_check.sv */
// testbench of the privilege check block
// assumes: APB master and pipeline requests driven here, task memory modelled
`timescale 1ns/10ps
module tb_privilege_protection_check
  import ppc_pkg::*;
;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, reqCurSp, taskStackSp, rspStackSp, rd;
  logic [3:0]  pstrb;
  logic        reqValid, reqPortDenied, rspValid, rspFault;
  logic        rspStackLoad, rspStackPush, rspStackRestore;
  ppc_op_t     reqOp;
  ppc_desc_t   reqDescType;
  ppc_tbl_t    reqDescTable;
  ppc_cause_t  rspCause;
  logic [1:0]  reqSelLevel, reqDescLevel, reqTargetLevel, runningPrivLevel, ioPrivLevel;
  logic [15:0] reqCurSs, taskStackSs, rspStackSs;
  logic [2:0]  portNum;
  int          nMismatch, testsRun, cycles;
  ////////////////////////////////////////////////////////////////
  ppc_priv_check dut_u (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .reqValid, .reqOp, .reqSelLevel, .reqDescLevel, .reqDescType,
    .reqDescTable, .reqTargetLevel, .reqPortDenied, .reqCurSs, .reqCurSp, .taskStackSs,
    .taskStackSp, .rspValid, .rspFault, .rspCause, .rspStackLoad, .rspStackPush,
    .rspStackRestore, .rspStackSs, .rspStackSp, .runningPrivLevel, .ioPrivLevel);
  ppc_task_mem model_u (.targetLevel(reqTargetLevel), .portNum, .stackSs(taskStackSs),
    .stackSp(taskStackSp), .portDenied(reqPortDenied));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      nMismatch++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////////
  task close_out();
    $display("checks %0d mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'(pready), 32'h1);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    apb(1'b1, a, d, e);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic ee);
    logic e;
    apb(1'b0, a, 32'h0, e);
    chk("prdata", rd, exp);
    chk("pslverr", 32'(e), 32'(ee));
  endtask
  task req(input ppc_op_t op, input ppc_desc_t dt, input ppc_tbl_t tb, input logic [1:0] sl,
           input logic [1:0] dl, input logic [1:0] tl, input logic [2:0] pn, input logic f);
    @(posedge sys_clk);
    reqValid <= 1'b1;
    reqOp <= op;
    reqDescType <= dt;
    reqDescTable <= tb;
    reqSelLevel <= sl;
    reqDescLevel <= dl;
    reqTargetLevel <= tl;
    portNum <= pn;
    @(posedge sys_clk);
    reqValid <= 1'b0;
    #1;
    chk("rspValid", 32'(rspValid), 32'h1);
    chk("rspFault", 32'(rspFault), 32'(f));
  endtask
  task lvl(input logic [1:0] l);
    chk("level", 32'(runningPrivLevel), 32'(l));
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset();
    lvl(2'h0);
    rdc(8'h04, 32'h0000_0004, 1'b0);
    rdc(8'h10, 32'h0, 1'b1);
    wr(8'h08, 32'hFFFF_FFFF);
    rdc(8'h08, 32'h0, 1'b0);
    req(PPC_OP_DATA, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h3, 2'h0, 2'h0, 3'h0, 1'b0);
    $display("test reset done");
  endtask
  task t_checks();
    wr(8'h00, 32'h0000_0033);
    chk("iolevel", 32'(ioPrivLevel), 32'h3);
    rdc(8'h04, 32'h0, 1'b0);
    req(PPC_OP_DATA, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h3, 2'h2, 2'h0, 3'h0, 1'b1);
    chk("cause", 32'(rspCause), 32'(PPC_CAUSE_PRIV));
    req(PPC_OP_JUMP, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h0, 1'b1);
    chk("cause", 32'(rspCause), 32'(PPC_CAUSE_TYPE));
    chk("load", 32'(rspStackLoad), 32'h0);
    rdc(8'h04, 32'h0002_0300, 1'b0);
    $display("test checks done");
  endtask
  task t_outward();
    req(PPC_OP_RETURN, PPC_DESC_CODE, PPC_TBL_GLOBAL, 2'h3, 2'h3, 2'h3, 3'h0, 1'b0);
    chk("restore", 32'(rspStackRestore), 32'h1);
    lvl(2'h3);
    req(PPC_OP_IO_FLAG, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h5, 1'b0);
    wr(8'h00, 32'h0000_0003);
    chk("iolevel", 32'(ioPrivLevel), 32'h3);
    rdc(8'h00, 32'h0000_0033, 1'b0);
    rdc(8'h04, 32'h0002_030B, 1'b0);
    chk("denied", 32'(rd[3:0]), 32'hB);
    $display("test outward done");
  endtask
  task t_inward();
    req(PPC_OP_CALL, PPC_DESC_CALL_GATE, PPC_TBL_LOCAL, 2'h3, 2'h3, 2'h0, 3'h0, 1'b0);
    chk("load", 32'(rspStackLoad), 32'h1);
    chk("push", 32'(rspStackPush), 32'h1);
    chk("ss", 32'(rspStackSs), 32'h5000);
    chk("sp", rspStackSp, 32'h7000_0000);
    lvl(2'h0);
    rdc(8'h08, 32'h1234, 1'b0);
    rdc(8'h0C, 32'hABCD_0000, 1'b0);
    wr(8'h00, 32'h0000_0003);
    chk("iolevel", 32'(ioPrivLevel), 32'h0);
    wr(8'h04, 32'h0000_0008);
    rdc(8'h04, 32'h0002_0300, 1'b0);
    req(PPC_OP_RETURN, PPC_DESC_CODE, PPC_TBL_LOCAL, 2'h3, 2'h3, 2'h3, 3'h0, 1'b0);
    chk("restore", 32'(rspStackRestore), 32'h1);
    chk("ss", 32'(rspStackSs), 32'h1234);
    chk("sp", rspStackSp, 32'hABCD_0000);
    $display("test inward done");
  endtask
  task t_io();
    req(PPC_OP_IO_PORT, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h2, 1'b0);
    req(PPC_OP_IO_PORT, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h5, 1'b1);
    chk("cause", 32'(rspCause), 32'(PPC_CAUSE_IO));
    req(PPC_OP_IO_FLAG, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h2, 1'b1);
    wr(8'h00, 32'h0000_0001);
    req(PPC_OP_IO_PORT, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h2, 1'b1);
    $display("test io done");
  endtask
  task t_types();
    req(PPC_OP_DATA, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h3, 2'h0, 3'h0, 1'b0);
    req(PPC_OP_INTR, PPC_DESC_CODE, PPC_TBL_INTR, 2'h3, 2'h3, 2'h0, 3'h0, 1'b1);
    req(PPC_OP_INTR, PPC_DESC_TRAP_GATE, PPC_TBL_GLOBAL, 2'h3, 2'h3, 2'h0, 3'h0, 1'b1);
    lvl(2'h3);
    req(PPC_OP_INTR, PPC_DESC_INT_GATE, PPC_TBL_INTR, 2'h3, 2'h3, 2'h0, 3'h0, 1'b0);
    chk("load", 32'(rspStackLoad), 32'h1);
    req(PPC_OP_JUMP, PPC_DESC_CODE, PPC_TBL_GLOBAL, 2'h0, 2'h0, 2'h0, 3'h0, 1'b0);
    chk("load", 32'(rspStackLoad), 32'h0);
    req(PPC_OP_JUMP, PPC_DESC_CODE, PPC_TBL_GLOBAL, 2'h0, 2'h2, 2'h2, 3'h0, 1'b1);
    lvl(2'h0);
    req(PPC_OP_INT_RETURN, PPC_DESC_TASK_GATE, PPC_TBL_INTR, 2'h0, 2'h3, 2'h2, 3'h0, 1'b0);
    lvl(2'h2);
    req(PPC_OP_CALL, PPC_DESC_CODE, PPC_TBL_GLOBAL, 2'h2, 2'h2, 2'h2, 3'h0, 1'b0);
    req(PPC_OP_DATA, PPC_DESC_DATA, PPC_TBL_GLOBAL, 2'h0, 2'h1, 2'h0, 3'h0, 1'b1);
    req(PPC_OP_JUMP, PPC_DESC_TASK_STATE, PPC_TBL_LOCAL, 2'h0, 2'h3, 2'h1, 3'h0, 1'b1);
    lvl(2'h2);
    req(PPC_OP_JUMP, PPC_DESC_TASK_STATE, PPC_TBL_GLOBAL, 2'h0, 2'h3, 2'h1, 3'h0, 1'b0);
    chk("load", 32'(rspStackLoad), 32'h0);
    lvl(2'h1);
    req(PPC_OP_CALL, PPC_DESC_CALL_GATE, PPC_TBL_GLOBAL, 2'h0, 2'h3, 2'h3, 3'h0, 1'b1);
    chk("cause", 32'(rspCause), 32'(PPC_CAUSE_LEVEL));
    $display("test types done");
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {rstn, psel, penable, pwrite, reqValid} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hF;
    reqOp = PPC_OP_DATA;
    reqDescType = PPC_DESC_CODE;
    reqDescTable = PPC_TBL_GLOBAL;
    {reqSelLevel, reqDescLevel, reqTargetLevel} = 6'h0;
    portNum = 3'h0;
    reqCurSs = 16'h1234;
    reqCurSp = 32'hABCD_0000;
    {nMismatch, testsRun, cycles} = 96'h0;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_checks();
    t_outward();
    t_inward();
    t_io();
    t_types();
    close_out();
  end
endmodule // tb_privilege_protection_check
